// ===== core/dual_simd_processing_elements.sv
`timescale 1ns/1ns
module dual_simd_processing_elements
  import dual_pe_pkg::*;
(
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_b_i,
  input  wire logic                              mode_wr_i,
  input  wire logic [dual_pe_pkg::MODE_W-1:0]    mode_data_i,
  input  wire logic                              instr_valid_i,
  input  wire dual_pe_pkg::alu_op_t              alu_op_i,
  input  wire dual_pe_pkg::mul_op_t              mul_op_i,
  input  wire dual_pe_pkg::shf_op_t              shf_op_i,
  input  wire dual_pe_pkg::fmt_t                 fmt_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     alu_a_idx_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     alu_b_idx_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     alu_dst_idx_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     mul_a_idx_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     mul_b_idx_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     mul_dst_idx_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     shf_a_idx_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     shf_dst_idx_i,
  input  wire logic                              ld_valid_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     ld_idx_i,
  input  wire logic [dual_pe_pkg::DATA_W-1:0]    ld_data_x_i,
  input  wire logic [dual_pe_pkg::DATA_W-1:0]    ld_data_y_i,
  input  wire logic                              st_valid_i,
  input  wire logic [dual_pe_pkg::IDX_W-1:0]     st_idx_i,
  output logic                                   st_valid_o,
  output logic                                   st_pair_o,
  output logic      [dual_pe_pkg::DATA_W-1:0]    st_data_x_o,
  output logic      [dual_pe_pkg::DATA_W-1:0]    st_data_y_o,
  output logic                                   second_element_enable_o,
  output logic                                   rf_secondary_o,
  output logic                                   mr_secondary_o,
  output logic                                   ag_secondary_o,
  output logic      [1:0]                        zero_flag_o,
  output logic      [1:0]                        neg_flag_o
);
  import dual_pe_pkg::*;

  logic [MODE_W-1:0] primary_mode_control;
  logic              s_valid;
  alu_op_t           s_alu_op;
  mul_op_t           s_mul_op;
  shf_op_t           s_shf_op;
  fmt_t              s_fmt;
  logic [IDX_W-1:0]  s_alu_dst;
  logic [IDX_W-1:0]  s_mul_dst;
  logic [IDX_W-1:0]  s_shf_dst;
  logic              s_rf_sec;
  logic              s_mr_sec;
  logic [1:0]        s_on;
  logic [1:0]        el_on;
  logic [1:0][DATA_W-1:0] ld_data;
  logic [1:0][DATA_W-1:0] st_data;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      primary_mode_control <= MODE_RESET;
    end else if (mode_wr_i) begin
      primary_mode_control <= mode_data_i;
    end
  end

  assign second_element_enable_o = primary_mode_control[MODE_Y_EN];
  assign rf_secondary_o = primary_mode_control[MODE_RF_SEC];
  assign mr_secondary_o = primary_mode_control[MODE_MR_SEC];
  assign ag_secondary_o = primary_mode_control[MODE_AG_SEC];

  // x always on, y by enable
  assign el_on   = {primary_mode_control[MODE_Y_EN], 1'b1};
  assign ld_data = {ld_data_y_i, ld_data_x_i};

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_valid   <= 1'b0;
      s_alu_op  <= ALU_NOP;
      s_mul_op  <= MUL_NOP;
      s_shf_op  <= SHF_NOP;
      s_fmt     <= FMT_FIXED;
      s_alu_dst <= '0;
      s_mul_dst <= '0;
      s_shf_dst <= '0;
      s_rf_sec  <= 1'b0;
      s_mr_sec  <= 1'b0;
      s_on      <= 2'b01;
    end else begin
      s_valid   <= instr_valid_i;
      s_alu_op  <= alu_op_i;
      s_mul_op  <= mul_op_i;
      s_shf_op  <= shf_op_i;
      s_fmt     <= fmt_i;
      s_alu_dst <= alu_dst_idx_i;
      s_mul_dst <= mul_dst_idx_i;
      s_shf_dst <= shf_dst_idx_i;
      s_rf_sec  <= primary_mode_control[MODE_RF_SEC];
      s_mr_sec  <= primary_mode_control[MODE_MR_SEC];
      s_on      <= el_on;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_valid_o <= 1'b0;
      st_pair_o  <= 1'b0;
    end else begin
      st_valid_o <= st_valid_i;
      st_pair_o  <= st_valid_i & el_on[1];
    end
  end

  assign st_data_x_o = st_data[0];
  assign st_data_y_o = st_data[1];

  for (genvar e = 0; e < 2; e++) begin : g_pe
    logic [N_RD-1:0][ADDR_W-1:0] ra;
    logic [N_RD-1:0][DATA_W-1:0] rd;
    logic [N_WR-1:0]             we;
    logic [N_WR-1:0][ADDR_W-1:0] wa;
    logic [N_WR-1:0][DATA_W-1:0] wd;
    logic [1:0][MR_W-1:0]        mr;
    logic [DATA_W-1:0]           alu_res;
    logic [DATA_W-1:0]           mul_res;
    logic [DATA_W-1:0]           shf_res;
    logic [63:0]                 prod;
    logic signed [7:0]           amt;
    logic                        act;
    logic                        zf;
    logic                        nf;

    assign act = s_valid & s_on[e];

    assign ra[0] = {primary_mode_control[MODE_RF_SEC], alu_a_idx_i};
    assign ra[1] = {primary_mode_control[MODE_RF_SEC], alu_b_idx_i};
    assign ra[2] = {primary_mode_control[MODE_RF_SEC], mul_a_idx_i};
    assign ra[3] = {primary_mode_control[MODE_RF_SEC], mul_b_idx_i};
    assign ra[4] = {primary_mode_control[MODE_RF_SEC], shf_a_idx_i};
    assign ra[5] = {primary_mode_control[MODE_RF_SEC], st_idx_i};

    assign we[0] = ld_valid_i & el_on[e];
    assign wa[0] = {primary_mode_control[MODE_RF_SEC], ld_idx_i};
    assign wd[0] = ld_data[e];
    assign we[1] = act & (s_shf_op != SHF_NOP);
    assign wa[1] = {s_rf_sec, s_shf_dst};
    assign wd[1] = shf_res;
    assign we[2] = act & (s_mul_op == MUL_MUL || s_mul_op == MUL_MRRD);
    assign wa[2] = {s_rf_sec, s_mul_dst};
    assign wd[2] = mul_res;
    assign we[3] = act & (s_alu_op != ALU_NOP);
    assign wa[3] = {s_rf_sec, s_alu_dst};
    assign wd[3] = alu_res;

    pe_register_file #(
      .DW (DATA_W),
      .AW (ADDR_W),
      .NR (N_RD),
      .NW (N_WR)
    ) u_rf (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .rd_addr_i (ra),
      .rd_data_o (rd),
      .wr_en_i   (we),
      .wr_addr_i (wa),
      .wr_data_i (wd)
    );

    assign st_data[e] = rd[5];

    always_comb begin
      alu_res = '0;
      case (s_alu_op)
        ALU_ADD:  alu_res = fx_pack(fx(rd[0]) + fx(rd[1]));
        ALU_SUB:  alu_res = fx_pack(fx(rd[0]) - fx(rd[1]));
        ALU_AND:  alu_res = fx_pack(fx(rd[0]) & fx(rd[1]));
        ALU_OR:   alu_res = fx_pack(fx(rd[0]) | fx(rd[1]));
        ALU_XOR:  alu_res = fx_pack(fx(rd[0]) ^ fx(rd[1]));
        ALU_FABS: alu_res = {1'b0, rd[0][38:0]};
        ALU_FNEG: alu_res = {~rd[0][39], rd[0][38:0]};
        default:  alu_res = '0;
      endcase
      if (s_fmt == FMT_SINGLE) begin
        alu_res = alu_res & SINGLE_MASK;
      end
    end

    assign prod = $signed(fx(rd[2])) * $signed(fx(rd[3]));
    always_comb begin
      mul_res = '0;
      case (s_mul_op)
        MUL_MUL: begin
          if (s_fmt == FMT_FIXED) begin
            mul_res = fx_pack(prod[31:0]);
          end else if (s_fmt == FMT_SINGLE) begin
            mul_res = fmul40(rd[2], rd[3]) & SINGLE_MASK;
          end else begin
            mul_res = fmul40(rd[2], rd[3]);
          end
        end
        MUL_MRRD: mul_res = fx_pack(mr[s_mr_sec][31:0]);
        default:  mul_res = '0;
      endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        mr <= '0;
      end else if (act && s_mul_op == MUL_MAC) begin
        mr[s_mr_sec] <= mr[s_mr_sec] + {{16{prod[63]}}, prod};
      end else if (act && s_mul_op == MUL_MRCLR) begin
        mr[s_mr_sec] <= '0;
      end
    end

    // Signed shift amount: positive left, negative right
    assign amt = rd[4][15:8];
    always_comb begin
      shf_res = '0;
      case (s_shf_op)
        SHF_LSH: begin
          if (!amt[7]) begin
            shf_res = fx_pack(fx(rd[4]) << amt);
          end else begin
            shf_res = fx_pack(fx(rd[4]) >> (-amt));
          end
        end
        SHF_ASH: begin
          if (!amt[7]) begin
            shf_res = fx_pack(fx(rd[4]) << amt);
          end else begin
            shf_res = fx_pack($signed(fx(rd[4])) >>> (-amt));
          end
        end
        SHF_PASS: shf_res = rd[4];
        default:  shf_res = '0;
      endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        zf <= 1'b0;
        nf <= 1'b0;
      end else if (act && s_alu_op != ALU_NOP) begin
        zf <= (alu_res == '0);
        nf <= alu_res[39];
      end
    end
    assign zero_flag_o[e] = zf;
    assign neg_flag_o[e]  = nf;
  end
endmodule

// ===== core/dual_pe_pkg.sv
package dual_pe_pkg;
  localparam int DATA_W   = 40;
  localparam int FIX_W    = 32;
  localparam int IDX_W    = 4;
  localparam int ADDR_W   = 5;
  localparam int MR_W     = 80;
  localparam int N_RD     = 6;
  localparam int N_WR     = 4;
  localparam int MODE_W   = 4;
  // Mode control bit positions
  localparam int MODE_Y_EN   = 0;
  localparam int MODE_RF_SEC = 1;
  localparam int MODE_MR_SEC = 2;
  localparam int MODE_AG_SEC = 3;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [39:0] SINGLE_MASK = 40'hff_ffff_ff00;
  localparam logic signed [9:0] EXP_BIAS = 10'sh07f;
  localparam logic signed [9:0] EXP_MAX  = 10'sh0ff;

  typedef enum logic [2:0] {
    ALU_NOP  = 3'h0,
    ALU_ADD  = 3'h1,
    ALU_SUB  = 3'h2,
    ALU_AND  = 3'h3,
    ALU_OR   = 3'h4,
    ALU_XOR  = 3'h5,
    ALU_FABS = 3'h6,
    ALU_FNEG = 3'h7
  } alu_op_t;

  typedef enum logic [2:0] {
    MUL_NOP  = 3'h0,
    MUL_MUL  = 3'h1,
    MUL_MAC  = 3'h2,
    MUL_MRRD = 3'h3,
    MUL_MRCLR = 3'h4
  } mul_op_t;

  typedef enum logic [1:0] {
    SHF_NOP  = 2'h0,
    SHF_LSH  = 2'h1,
    SHF_ASH  = 2'h2,
    SHF_PASS = 2'h3
  } shf_op_t;

  typedef enum logic [1:0] {
    FMT_FIXED  = 2'h0,
    FMT_SINGLE = 2'h1,
    FMT_EXT    = 2'h2
  } fmt_t;

  // Fixed-point value sits in the upper 32 bits of a register
  function automatic logic [31:0] fx(input logic [39:0] v);
    return v[39:8];
  endfunction

  function automatic logic [39:0] fx_pack(input logic [31:0] v);
    return {v, 8'h00};
  endfunction

  // Extended float multiply; single precision is the same word, truncated
  function automatic logic [39:0] fmul40(input logic [39:0] a, input logic [39:0] b);
    logic [63:0]       p;
    logic signed [9:0] e;
    logic [30:0]       m;
    logic              s;
    s = a[39] ^ b[39];
    p = {1'b1, a[30:0]} * {1'b1, b[30:0]};
    e = $signed({2'b00, a[38:31]}) + $signed({2'b00, b[38:31]}) - EXP_BIAS;
    if (p[63]) begin
      m = p[62:32];
      e = e + 10'sd1;
    end else begin
      m = p[61:31];
    end
    if (a[38:31] == 8'h00 || b[38:31] == 8'h00 || e <= 10'sd0) begin
      return {s, 39'h0};
    end else if (e >= EXP_MAX) begin
      return {s, 8'hff, 31'h0};
    end
    return {s, e[7:0], m};
  endfunction
endpackage

// ===== core/pe_register_file.sv
`timescale 1ns/1ns
// Multi-port register file, registered reads with write-first forwarding
module pe_register_file #(
  parameter int DW = 40,
  parameter int AW = 5,
  parameter int NR = 6,
  parameter int NW = 4
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic [NR-1:0][AW-1:0]  rd_addr_i,
  output logic      [NR-1:0][DW-1:0]  rd_data_o,
  input  wire logic [NW-1:0]          wr_en_i,
  input  wire logic [NW-1:0][AW-1:0]  wr_addr_i,
  input  wire logic [NW-1:0][DW-1:0]  wr_data_i
);
  logic [DW-1:0] mem [2**AW];

  if (NR < 1 || NW < 1 || AW < 1) begin : g_bad
    $error("pe_register_file needs at least one port and one address bit");
  end

  // Higher-numbered write port wins on a clash
  always_ff @(posedge sys_clk_i) begin
    for (int w = 0; w < NW; w++) begin
      if (wr_en_i[w]) begin
        mem[wr_addr_i[w]] <= wr_data_i[w];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= '0;
    end else begin
      for (int r = 0; r < NR; r++) begin
        rd_data_o[r] <= mem[rd_addr_i[r]];
        for (int w = 0; w < NW; w++) begin
          if (wr_en_i[w] && wr_addr_i[w] == rd_addr_i[r]) begin
            rd_data_o[r] <= wr_data_i[w];
          end
        end
      end
    end
  end
endmodule

// ===== verif/dual_pe_sva.sv
`timescale 1ns/1ns
module dual_pe_chk
  import dual_pe_pkg::*;
(
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           mode_wr_i,
  input  wire logic [dual_pe_pkg::MODE_W-1:0] mode_data_i,
  input  wire logic                           instr_valid_i,
  input  wire dual_pe_pkg::alu_op_t           alu_op_i,
  input  wire logic                           st_valid_i,
  input  wire logic                           st_valid_o,
  input  wire logic                           st_pair_o,
  input  wire logic                           second_element_enable_o,
  input  wire logic                           rf_secondary_o,
  input  wire logic                           mr_secondary_o,
  input  wire logic                           ag_secondary_o,
  input  wire logic [1:0]                     zero_flag_o,
  input  wire logic [1:0]                     neg_flag_o
);
  logic [3:0] mode_bits;
  logic       y_off;
  assign mode_bits = {ag_secondary_o, mr_secondary_o, rf_secondary_o, second_element_enable_o};
  assign y_off = !second_element_enable_o;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_store_answer: assert property (st_valid_i |=> st_valid_o)
    else $error("store answer missing");
  a_store_quiet: assert property (!st_valid_i |=> !st_valid_o)
    else $error("store answer without request");
  a_pair_mode: assert property (st_valid_o |-> st_pair_o == $past(second_element_enable_o))
    else $error("store pairing disagrees with mode");
  a_pair_valid: assert property (st_pair_o |-> st_valid_o)
    else $error("pair flag outside store");
  a_mode_load: assert property (mode_wr_i |=> mode_bits == $past(mode_data_i))
    else $error("mode bits not loaded");
  a_mode_hold: assert property (!mode_wr_i |=> $stable(mode_bits))
    else $error("mode bits changed without write");
  a_reset_state: assert property ($rose(rst_b_i) |-> mode_bits == 4'h0 && !st_valid_o)
    else $error("state after reset wrong");
  // Flags move two edges after the issuing edge: one to stage, one to write
  a_flags_hold: assert property (!(instr_valid_i && alu_op_i != ALU_NOP)
    |-> ##2 $stable({zero_flag_o, neg_flag_o}))
    else $error("flags changed without alu op");
  a_yflag_frozen: assert property (y_off && $past(y_off)
    |=> $stable({zero_flag_o[1], neg_flag_o[1]}))
    else $error("second element flags changed while off");

  c_pair_store: cover property (st_valid_o && st_pair_o);
  c_secondary: cover property (mode_wr_i && mode_data_i[1]);
  c_dual_issue: cover property (instr_valid_i && second_element_enable_o);
endmodule

bind dual_simd_processing_elements dual_pe_chk u_chk (
  .sys_clk_i, .rst_b_i, .mode_wr_i, .mode_data_i, .instr_valid_i, .alu_op_i, .st_valid_i,
  .st_valid_o, .st_pair_o, .second_element_enable_o, .rf_secondary_o, .mr_secondary_o,
  .ag_secondary_o, .zero_flag_o, .neg_flag_o
);

// ===== verif/pe_store_sink.sv
`timescale 1ns/1ns
// Memory side of the store path; counts values delivered
module pe_store_sink (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic wr_valid_i,
  input  wire logic wr_pair_i,
  output int        vals_o
);
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vals_o <= 0;
    end else if (wr_valid_i) begin
      vals_o <= vals_o + (wr_pair_i ? 2 : 1);
    end
  end
endmodule

// ===== verif/dual_simd_processing_elements_tb.sv
`timescale 1ns/1ns
module dual_simd_processing_elements_tb;
  import dual_pe_pkg::*;
  typedef struct packed {
    logic        mw;
    logic [3:0]  md;
    logic        iv;
    alu_op_t     ao;
    mul_op_t     mo;
    fmt_t        f;
    logic [3:0]  a;
    logic [3:0]  b;
    logic [3:0]  d;
    logic        lv;
    logic [3:0]  li;
    logic [39:0] lx;
    logic [39:0] ly;
    logic        sv;
    logic [3:0]  si;
  } cyc_t;
  cyc_t        n;
  logic        sys_clk_i, rst_b_i, mode_wr_i, instr_valid_i, ld_valid_i, st_valid_i;
  logic [3:0]  mode_data_i, alu_a_idx_i, alu_b_idx_i, alu_dst_idx_i, mul_a_idx_i;
  logic [3:0]  mul_b_idx_i, mul_dst_idx_i, shf_a_idx_i, shf_dst_idx_i, ld_idx_i, st_idx_i;
  alu_op_t     alu_op_i, op;
  mul_op_t     mul_op_i;
  shf_op_t     shf_op_i;
  fmt_t        fmt_i;
  logic [39:0] ld_data_x_i, ld_data_y_i, st_data_x_o, st_data_y_o, xa, xb, ya, yb, ex, ey;
  logic        st_valid_o, st_pair_o, second_element_enable_o, rf_secondary_o;
  logic        mr_secondary_o, ag_secondary_o;
  logic [1:0]  zero_flag_o, neg_flag_o, fy;
  logic [3:0]  a, b, d;
  int          mismatches, cmp_count, exp_vals, vals, i;

  dual_simd_processing_elements DUT (
    .sys_clk_i, .rst_b_i, .mode_wr_i, .mode_data_i, .instr_valid_i, .alu_op_i, .mul_op_i,
    .shf_op_i, .fmt_i, .alu_a_idx_i, .alu_b_idx_i, .alu_dst_idx_i, .mul_a_idx_i, .mul_b_idx_i,
    .mul_dst_idx_i, .shf_a_idx_i, .shf_dst_idx_i, .ld_valid_i, .ld_idx_i, .ld_data_x_i,
    .ld_data_y_i, .st_valid_i, .st_idx_i, .st_valid_o, .st_pair_o, .st_data_x_o, .st_data_y_o,
    .second_element_enable_o, .rf_secondary_o, .mr_secondary_o, .ag_secondary_o,
    .zero_flag_o, .neg_flag_o
  );
  pe_store_sink u_sink (.sys_clk_i, .rst_b_i, .wr_valid_i(st_valid_o), .wr_pair_i(st_pair_o),
    .vals_o(vals));

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // Every input is written exactly once per edge
  task automatic apply();
    mode_wr_i <= n.mw;
    mode_data_i <= n.md;
    instr_valid_i <= n.iv;
    alu_op_i <= n.ao;
    mul_op_i <= n.mo;
    shf_op_i <= shf_op_t'(n.iv ? SHF_PASS : SHF_NOP);
    fmt_i <= n.f;
    alu_a_idx_i <= n.a;
    alu_b_idx_i <= n.b;
    alu_dst_idx_i <= n.d;
    mul_a_idx_i <= n.a;
    mul_b_idx_i <= n.b;
    mul_dst_idx_i <= n.d + 4'h1;
    shf_a_idx_i <= n.a;
    shf_dst_idx_i <= n.d + 4'h2;
    ld_valid_i <= n.lv;
    ld_idx_i <= n.li;
    ld_data_x_i <= n.lx;
    ld_data_y_i <= n.ly;
    st_valid_i <= n.sv;
    st_idx_i <= n.si;
    n = '0;
  endtask
  task automatic tick();
    @(posedge sys_clk_i);
    apply();
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic mode(input logic [3:0] v);
    n.mw = 1'b1;
    n.md = v;
    tick();
  endtask
  task automatic load(input logic [3:0] idx, input logic [39:0] x, input logic [39:0] y);
    n.lv = 1'b1;
    n.li = idx;
    n.lx = x;
    n.ly = y;
    tick();
  endtask
  task automatic issue(input alu_op_t ao, input mul_op_t mo, input fmt_t f);
    n.iv = 1'b1;
    n.ao = ao;
    n.mo = mo;
    n.f = f;
    n.a = a;
    n.b = b;
    n.d = d;
    tick();
  endtask
  task automatic store(input logic [3:0] idx, input logic [39:0] x, input logic [39:0] y,
                       input logic pr);
    n.sv = 1'b1;
    n.si = idx;
    tick();
    tick();
    #1;
    exp_vals += pr ? 2 : 1;
    chk(st_valid_o, 1'b1);
    chk(st_pair_o, pr);
    chk(st_data_x_o, x);
    if (pr) chk(st_data_y_o, y);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [39:0] rnd();
    return {$urandom(), 8'h00};
  endfunction
  function automatic logic [39:0] exp_alu(alu_op_t o, logic [39:0] p, logic [39:0] q);
    case (o)
      ALU_ADD: return {p[39:8] + q[39:8], 8'h00};
      ALU_SUB: return {p[39:8] - q[39:8], 8'h00};
      ALU_AND: return p & q;
      ALU_OR:  return p | q;
      default: return p ^ q;
    endcase
  endfunction
  function automatic logic [39:0] exp_mul(logic [39:0] p, logic [39:0] q);
    logic [31:0] r;
    r = p[39:8] * q[39:8];
    return {r, 8'h00};
  endfunction

  initial begin
    void'($urandom(99));
    n = '0;
    apply();
    rst_b_i = 1'b0;
    fy = 2'h0;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk({mode_bits_now(), st_valid_o}, 40'h0);
    for (i = 0; i < 12; i++) begin
      mode({3'h0, i[0]});
      a = 4'($urandom());
      b = a + 4'(1 + $urandom() % 15);
      d = 4'($urandom() % 14);
      xa = rnd();
      xb = rnd();
      ya = rnd();
      yb = rnd();
      load(a, xa, ya);
      load(b, xb, yb);
      op = alu_op_t'(1 + $urandom() % 5);
      issue(op, MUL_MUL, FMT_FIXED);
      ex = exp_alu(op, xa, xb);
      ey = exp_alu(op, ya, yb);
      store(d, ex, ey, i[0]);
      if (i[0]) fy = {ey == 40'h0, ey[39]};
      chk({zero_flag_o[1], neg_flag_o[1], zero_flag_o[0], neg_flag_o[0]},
          {fy, ex == 40'h0, ex[39]});
      store(d + 4'h1, exp_mul(xa, xb), exp_mul(ya, yb), i[0]);
      store(d + 4'h2, xa, ya, i[0]);
    end
    // Second element off: its copy of the pass result must survive
    mode(4'h0);
    xa = rnd();
    load(a, xa, rnd());
    issue(ALU_XOR, MUL_NOP, FMT_FIXED);
    mode(4'h1);
    store(d + 4'h2, xa, ya, 1'b1);
    chk({zero_flag_o[1], neg_flag_o[1]}, fy);
    xa = {$urandom(), 8'($urandom())};
    load(a, xa, ~xa);
    issue(ALU_FABS, MUL_NOP, FMT_EXT);
    store(d, {1'b0, xa[38:0]}, {1'b0, ~xa[38:0]}, 1'b1);
    // Reload in case the previous result landed on the operand register
    load(a, xa, ~xa);
    issue(ALU_FNEG, MUL_NOP, FMT_SINGLE);
    store(d, {~xa[39], xa[38:0]} & SINGLE_MASK, {xa[39], ~xa[38:0]} & SINGLE_MASK, 1'b1);
    load(d, xb, yb);
    mode(4'hf);
    load(d, xa, ya);
    store(d, xa, ya, 1'b1);
    mode(4'h1);
    store(d, xb, yb, 1'b1);
    // Accumulate twice into the primary result, then read it back
    a = 4'h0;
    b = 4'h1;
    d = 4'h4;
    load(a, xa, ya);
    load(b, xb, yb);
    issue(ALU_NOP, MUL_MRCLR, FMT_FIXED);
    issue(ALU_NOP, MUL_MAC, FMT_FIXED);
    issue(ALU_NOP, MUL_MAC, FMT_FIXED);
    issue(ALU_NOP, MUL_MRRD, FMT_FIXED);
    ex = exp_mul(xa, xb);
    ey = exp_mul(ya, yb);
    store(d + 4'h1, {ex[38:8], 9'h000}, {ey[38:8], 9'h000}, 1'b1);
    // Secondary result copy was never touched
    mode(4'h5);
    issue(ALU_NOP, MUL_MRRD, FMT_FIXED);
    store(d + 4'h1, 40'h0, 40'h0, 1'b1);
    tick();
    #1;
    chk(vals, exp_vals);
    tally_and_finish();
  end

  function automatic logic [3:0] mode_bits_now();
    return {ag_secondary_o, mr_secondary_o, rf_secondary_o, second_element_enable_o};
  endfunction
endmodule
